// ===== mcs_cfg.svh
`ifndef MCS_CFG_SVH
`define MCS_CFG_SVH

// Register address and reset image of the clock select register
`define MCS_REG_ADDR     8'h81
`define MCS_REG_RESET    8'h00
// Field positions inside the register
`define MCS_RSV_BIT      7
`define MCS_SEL_MSB      6
`define MCS_SEL_LSB      4
`define MCS_RATE_BIT     3
`define MCS_LOW_MSB      2
// Idle bus answer when nothing is read
`define MCS_IDLE_DATA    8'h00
// Phase increments for a 32-bit accumulator at 50 MHz
`define MCS_INC_2048     32'h0a7c5ac4
`define MCS_INC_1544     32'h07e7c06e
// Retune settling time and core clock period, both in ns
`define MCS_SETTLE_NS    1280
`define MCS_CLK_NS       20
// Least settling time rounds up to whole cycles
`define MCS_SETTLE_CYC   ((`MCS_SETTLE_NS + `MCS_CLK_NS - 1) / `MCS_CLK_NS)

`endif

// ===== mcs_pkg.sv
package mcs_pkg;

    // Retune sequencer states, one-hot
    typedef enum logic [1:0] {
        MCS_ST_LOCKED  = 2'b01,
        MCS_ST_RETUNE  = 2'b10
    } mcs_state_t;

    // Select code width
    typedef logic [2:0] mcs_sel_t;

endpackage : mcs_pkg

// ===== mcs_nco.sv
`timescale 1ns/1ns
`default_nettype none

// Phase accumulator standing in for the synthesizer core
module mcs_nco #(
    parameter int ACC_W = 32            // Accumulator width
) (
    input  wire logic             core_clk,
    input  wire logic             rst_n,
    input  wire logic             clear,
    input  wire logic [ACC_W-1:0] incr,
    output logic                  phase_msb
);

    logic [ACC_W-1:0] acc_ff;           // Running phase
    logic [ACC_W-1:0] nxt_acc;          // Next phase

    // Restart from zero while retuning
    assign nxt_acc   = clear ? '0 : acc_ff + incr;
    assign phase_msb = acc_ff[ACC_W-1];

    // Phase register
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            acc_ff <= '0;
        end else begin
            acc_ff <= nxt_acc;
        end
    end

endmodule : mcs_nco

`default_nettype wire

// ===== mcs_clock_select.sv
`timescale 1ns/1ns
`default_nettype none
`include "mcs_cfg.svh"

// Summary of operation
// - Synthesizer output rate follows the rate bit only
// - A write that changes select or rate retunes synthesizer
// - Register splits into D[7:3] and D[2:0]
// - Rate bit picks the external reference that the synthesizer locks to
// - Reserved D7 and select bit 2 reset zero
module mcs_clock_select #(
    parameter int SETTLE_CYC = `MCS_SETTLE_CYC  // Retune settling cycles
) (
    input  wire logic       core_clk,
    input  wire logic       rst_n,
    input  wire logic       cs_n,
    input  wire logic       wr_n,
    input  wire logic       rd_n,
    input  wire logic [7:0] addr,
    input  wire logic [7:0] data_in,
    output logic      [7:0] data_out,
    output logic            data_oe,
    input  wire logic       e1_reference_input,
    input  wire logic       t1_reference_input,
    output logic            synthesized_clock_output,
    output logic            synth_locked
);

    // Pin synchronisers, two stages, plus a history stage for the write strobe and references
    logic [2:0] wr_sync_ff;             // Write strobe stages
    logic [1:0] rd_sync_ff;             // Read strobe stages
    logic [1:0] cs_sync_ff;             // Chip select stages
    logic [7:0] addr_s1_ff, addr_s2_ff; // Address stages
    logic [7:0] din_s1_ff, din_s2_ff;   // Write data stages
    logic [2:0] e1_sync_ff, t1_sync_ff; // Reference stages plus history

    // Register and control state
    logic [7:0]             mcs_reg_ff;     // Clock select register
    logic [7:0]             nxt_reg;        // Written image
    mcs_pkg::mcs_state_t    state_ff;       // Retune sequencer
    mcs_pkg::mcs_state_t    nxt_state;
    logic [15:0]            settle_cnt_ff;  // Cycles spent retuning
    logic                   ref_seen_ff;    // Reference edge seen while retuning
    logic [7:0]             dout_ff;        // Read data register
    logic                   doe_ff;         // Read drive enable
    logic                   synth_clk_ff;   // Gated synthesized clock
    logic                   locked_ff;      // Lock flag

    // Decoded terms
    wire        wr_take;                // Write accepted this cycle
    wire        rd_live;                // Register being read
    wire        hit;                    // Address matches
    wire        tune_change;            // Select or rate differs
    wire        settle_done;            // Settling time over
    wire        ref_edge;               // Rising edge on active reference
    wire [31:0] incr;                   // Phase increment in use
    wire        phase_msb;              // Accumulator top bit
    wire        rate_bit;               // Rate choice in the register
    wire [2:0]  synth_select_code;      // Select code in the register

    // Synchronise every pin before use
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_sync_ff <= 3'h7;
            rd_sync_ff <= 2'h3;
            cs_sync_ff <= 2'h3;
            addr_s1_ff <= 8'h00;
            addr_s2_ff <= 8'h00;
            din_s1_ff  <= 8'h00;
            din_s2_ff  <= 8'h00;
            e1_sync_ff <= 3'h0;
            t1_sync_ff <= 3'h0;
        end else begin
            wr_sync_ff <= {wr_sync_ff[1:0], wr_n};
            rd_sync_ff <= {rd_sync_ff[0], rd_n};
            cs_sync_ff <= {cs_sync_ff[0], cs_n};
            addr_s1_ff <= addr;
            addr_s2_ff <= addr_s1_ff;
            din_s1_ff  <= data_in;
            din_s2_ff  <= din_s1_ff;
            e1_sync_ff <= {e1_sync_ff[1:0], e1_reference_input};
            t1_sync_ff <= {t1_sync_ff[1:0], t1_reference_input};
        end
    end

    // Address decode, write strobe edge and read strobe level
    assign hit     = (addr_s2_ff == `MCS_REG_ADDR);
    assign wr_take = wr_sync_ff[2] & ~wr_sync_ff[1] & ~cs_sync_ff[1] & hit;
    assign rd_live = ~rd_sync_ff[1] & ~cs_sync_ff[1] & hit;

    // Reserved bit forced to zero on every write
    assign nxt_reg = {1'b0, din_s2_ff[`MCS_SEL_MSB:0]};

    // Field views
    assign synth_select_code = mcs_reg_ff[`MCS_SEL_MSB:`MCS_SEL_LSB];
    assign rate_bit          = mcs_reg_ff[`MCS_RATE_BIT];

    // Retune only when the select or rate field really changes
    assign tune_change = wr_take &
        (nxt_reg[`MCS_SEL_MSB:`MCS_RATE_BIT] != mcs_reg_ff[`MCS_SEL_MSB:`MCS_RATE_BIT]);

    // Reference for lock: T1 input when the 1544 rate is chosen
    assign ref_edge = rate_bit ? (t1_sync_ff[1] & ~t1_sync_ff[2])
                               : (e1_sync_ff[1] & ~e1_sync_ff[2]);

    // Output rate follows the rate bit for every select code
    assign incr = rate_bit ? `MCS_INC_1544 : `MCS_INC_2048;

    assign settle_done = (settle_cnt_ff >= 16'(SETTLE_CYC - 1));

    // Register write; the two bit groups land together in one write
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            mcs_reg_ff <= `MCS_REG_RESET;
        end else if (wr_take) begin
            mcs_reg_ff <= nxt_reg;
        end
    end

    // Sequencer next state
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            mcs_pkg::MCS_ST_LOCKED: begin
                if (tune_change) begin
                    nxt_state = mcs_pkg::MCS_ST_RETUNE;
                end
            end
            mcs_pkg::MCS_ST_RETUNE: begin
                // A fresh change restarts the settle period
                if (!tune_change && settle_done && (ref_seen_ff || ref_edge)) begin
                    nxt_state = mcs_pkg::MCS_ST_LOCKED;
                end
            end
            default: begin
                nxt_state = mcs_pkg::MCS_ST_RETUNE;
            end
        endcase
    end

    // Sequencer state, settle counter and reference watch
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_ff      <= mcs_pkg::MCS_ST_RETUNE;
            settle_cnt_ff <= 16'h0000;
            ref_seen_ff   <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            if (tune_change || state_ff != mcs_pkg::MCS_ST_RETUNE) begin
                settle_cnt_ff <= 16'h0000;
                ref_seen_ff   <= 1'b0;
            end else begin
                settle_cnt_ff <= settle_done ? settle_cnt_ff : settle_cnt_ff + 16'h0001;
                ref_seen_ff   <= ref_seen_ff | ref_edge;
            end
        end
    end

    // Synthesizer core; held at zero phase while retuning
    mcs_nco #(
        .ACC_W (32)
    ) u_nco (
        .core_clk  (core_clk),
        .rst_n     (rst_n),
        .clear     (state_ff == mcs_pkg::MCS_ST_RETUNE),
        .incr      (incr),
        .phase_msb (phase_msb)
    );

    // Output flops: clock gated low until locked, read port
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            synth_clk_ff <= 1'b0;
            locked_ff    <= 1'b0;
            dout_ff      <= `MCS_IDLE_DATA;
            doe_ff       <= 1'b0;
        end else begin
            synth_clk_ff <= phase_msb & (state_ff == mcs_pkg::MCS_ST_LOCKED);
            locked_ff    <= (state_ff == mcs_pkg::MCS_ST_LOCKED);
            dout_ff      <= rd_live ? mcs_reg_ff : `MCS_IDLE_DATA;
            doe_ff       <= rd_live;
        end
    end

    assign synthesized_clock_output = synth_clk_ff;
    assign synth_locked             = locked_ff;
    assign data_out                 = dout_ff;
    assign data_oe                  = doe_ff;

    // Checks on the register and retune behaviour
    sequence write_sel_change_s;
        tune_change;
    endsequence

    sequence retune_hold_s;
        (state_ff == mcs_pkg::MCS_ST_RETUNE) [*2];
    endsequence

    rsv_bit_zero_a: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        mcs_reg_ff[`MCS_RSV_BIT] == 1'b0 && dout_ff[`MCS_RSV_BIT] == 1'b0)
        else $error("reserved bit not zero");

    retune_start_a: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        write_sel_change_s |=> retune_hold_s)
        else $error("select change did not retune");

    lock_drop_a: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        write_sel_change_s |-> ##2 !locked_ff ##1 !synth_clk_ff)
        else $error("lock not dropped on retune");

    low_write_keep_a: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        wr_take && state_ff == mcs_pkg::MCS_ST_LOCKED &&
        nxt_reg[`MCS_SEL_MSB:`MCS_RATE_BIT] == mcs_reg_ff[`MCS_SEL_MSB:`MCS_RATE_BIT]
        |=> state_ff == mcs_pkg::MCS_ST_LOCKED)
        else $error("low group write caused retune");

    settle_min_a: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        $rose(state_ff == mcs_pkg::MCS_ST_LOCKED) |-> $past(settle_done))
        else $error("locked before settling time");

    // Locked synthesizer phase must step by the documented rate increment
    rate_2048_a: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        state_ff == mcs_pkg::MCS_ST_LOCKED && $past(state_ff == mcs_pkg::MCS_ST_LOCKED) &&
        !rate_bit |-> u_nco.acc_ff == $past(u_nco.acc_ff) + `MCS_INC_2048)
        else $error("rate 0 not 2048 kHz");

    rate_1544_a: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        state_ff == mcs_pkg::MCS_ST_LOCKED && $past(state_ff == mcs_pkg::MCS_ST_LOCKED) &&
        rate_bit |-> u_nco.acc_ff == $past(u_nco.acc_ff) + `MCS_INC_1544)
        else $error("rate 1 not 1544 kHz");

    gated_clock_a: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        !locked_ff |-> !synth_clk_ff)
        else $error("clock running while unlocked");

    write_store_a: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        wr_take |=> synth_select_code == $past(din_s2_ff[`MCS_SEL_MSB:`MCS_SEL_LSB]))
        else $error("select code not stored");

    read_back_a: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        rd_live && !wr_take |=> doe_ff && dout_ff == mcs_reg_ff)
        else $error("read data wrong");

endmodule : mcs_clock_select

`default_nettype wire

// ===== mcs_ref_model.sv
`timescale 1ns/1ns
`default_nettype none

// Free-running reference oscillators on the far side of the synthesizer
module mcs_ref_model #(
    parameter int E1_HALF_NS = 244,  // About 2048 kHz
    parameter int T1_HALF_NS = 324   // About 1544 kHz
) (
    output logic e1_reference_input,
    output logic t1_reference_input
);
    // Oscillators run free from power-up, with unrelated phases
    initial begin
        e1_reference_input = 1'b0;
        forever #(E1_HALF_NS) e1_reference_input = ~e1_reference_input;
    end
    initial begin
        t1_reference_input = 1'b0;
        #(T1_HALF_NS / 3);
        forever #(T1_HALF_NS) t1_reference_input = ~t1_reference_input;
    end
endmodule : mcs_ref_model

`default_nettype wire

// ===== tb_top.sv
`timescale 1ns/1ns
`default_nettype none

// One comparison, counted; mismatch reported at once
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin errors++; \
    $display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, g, e); end end

module tb_top;
    logic       core_clk, rst_n, cs_n, wr_n, rd_n;   // Clock, reset, strobes
    logic [7:0] addr, data_in, data_out;             // Host bus
    logic       data_oe, e1_ref, t1_ref, clk_out, synth_locked;
    int         errors, cmp_count, drops;            // Tallies
    logic       lock_q;                              // Lock delayed one cycle
    logic [7:0] rd_val;                              // Last read data
    logic       rd_oe;                               // Last read drive flag

    mcs_ref_model REF (.e1_reference_input(e1_ref), .t1_reference_input(t1_ref));
    mcs_clock_select #(.SETTLE_CYC(4)) DUT (
        .core_clk(core_clk), .rst_n(rst_n), .cs_n(cs_n), .wr_n(wr_n), .rd_n(rd_n),
        .addr(addr), .data_in(data_in), .data_out(data_out), .data_oe(data_oe),
        .e1_reference_input(e1_ref), .t1_reference_input(t1_ref),
        .synthesized_clock_output(clk_out), .synth_locked(synth_locked));

    // 50 MHz clock
    initial begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end

    // Counts every loss of lock, i.e. every retune
    always @(posedge core_clk) begin
        if (lock_q === 1'b1 && synth_locked === 1'b0) drops++;
        lock_q <= synth_locked;
    end

    // Verdict and end of run
    task give_verdict();
        if (errors == 0 && cmp_count > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : give_verdict

    // Host write: pins settle, wr_n pulse, recovery gap
    task wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk) #2 addr = a; data_in = d; cs_n = 1'b0;
        repeat (3) @(posedge core_clk);
        #2 wr_n = 1'b0;
        repeat (5) @(posedge core_clk);
        #2 wr_n = 1'b1; cs_n = 1'b1;
        repeat (5) @(posedge core_clk);
    endtask : wr

    // Host read: sample after synchroniser latency, then release
    task rd(input logic [7:0] a);
        @(posedge core_clk) #2 addr = a; cs_n = 1'b0; rd_n = 1'b0;
        repeat (5) @(posedge core_clk);
        #1 rd_val = data_out; rd_oe = data_oe;
        #1 cs_n = 1'b1; rd_n = 1'b1;
        repeat (5) @(posedge core_clk);
    endtask : rd

    // Bounded wait for lock
    task wait_lock();
        int n;
        n = 0;
        while (synth_locked !== 1'b1) begin
            @(posedge core_clk) #1 n++;
            if (n > 400) begin `CHK(synth_locked, 1'b1) give_verdict(); end
        end
    endtask : wait_lock

    // Cycles spanned by 32 output periods
    task meas(input int lo, input int hi);
        int n, edges, cyc;
        logic prev;
        n = 0; edges = 0; cyc = 0; prev = clk_out;
        while (edges < 33 && n < 3000) begin
            @(posedge core_clk) #1 n++; cyc++;
            if (prev === 1'b0 && clk_out === 1'b1) begin edges++; if (edges == 1) cyc = 0; end
            prev = clk_out;
        end
        `CHK(edges, 33)
        if (edges != 33) give_verdict();
        `CHK(cyc >= lo && cyc <= hi, 1'b1)
    endtask : meas

    // Reset image and first lock
    task t_reset();
        wait_lock();
        rd(8'h81); `CHK(rd_val, 8'h00)
        `CHK(rd_oe, 1'b1)
        `CHK(data_oe, 1'b0)
    endtask : t_reset

    // Reserved bit write is dropped, no retune
    task t_reserved();
        int d0;
        d0 = drops;
        wr(8'h81, 8'h80); rd(8'h81); `CHK(rd_val, 8'h00)
        `CHK(drops - d0, 0)
    endtask : t_reserved

    // Lower group alone: one write, no retune; then unmapped access
    task t_lower();
        int d0;
        d0 = drops;
        wr(8'h81, 8'h05); rd(8'h81); `CHK(rd_val, 8'h05)
        `CHK(drops - d0, 0)
        meas(780, 783);
        wr(8'h80, 8'h7a); rd(8'h80); `CHK(rd_oe, 1'b0)
        `CHK(rd_val, 8'h00)
        rd(8'h81); `CHK(rd_val, 8'h05)
    endtask : t_lower

    // Every select code, rate toggling, upper group only per write; then a lower group write, no retune
    task t_codes();
        int d0;
        logic [7:0] v;
        for (int i = 1; i <= 9; i++) begin
            v = (i == 9) ? 8'h0d : {1'b0, i[2:0], i[0], 3'h5};
            d0 = drops;
            wr(8'h81, v); wait_lock();
            `CHK(drops - d0, 1)
            if (v[3]) meas(1035, 1038);
            else meas(780, 783);
            rd(8'h81); `CHK(rd_val, v)
        end
        d0 = drops;
        wr(8'h81, 8'h0a); rd(8'h81); `CHK(rd_val, 8'h0a)
        `CHK(drops - d0, 0)
    endtask : t_codes

    // Mid-run reset: select bit 2 set, then cleared by reset
    task t_midreset();
        wr(8'h81, 8'h42); wait_lock();
        rd(8'h81); `CHK(rd_val, 8'h42)
        @(posedge core_clk) #2 rst_n = 1'b0;
        repeat (10) @(posedge core_clk);
        #2 rst_n = 1'b1;
        `CHK(synth_locked, 1'b0)
        t_reset();
    endtask : t_midreset

    // Main sequence
    initial begin
        rst_n = 1'b0; cs_n = 1'b1; wr_n = 1'b1; rd_n = 1'b1;
        addr = 8'h00; data_in = 8'h00; errors = 0; cmp_count = 0;
        repeat (10) @(posedge core_clk);
        #2 rst_n = 1'b1;
        t_reset();
        t_reserved();
        t_lower();
        t_codes();
        t_midreset();
        give_verdict();
    end
endmodule : tb_top

`default_nettype wire
